// File: bench/test_quad_gain_mixer_delay_config.sv
/*
  Self-checking bench for the quad gain, coarse mixer and output lag block.
  Assumes the block's AXI4-Lite slave and valid/ready sample ports on one 25 MHz clock.
*/
`timescale 1ns/1ns
`default_nettype none
module test_quad_gain_mixer_delay_config;
  typedef mixer_cfg_pkg::sample_quad_s tb_quad_s;
  localparam logic [1:0] OK = mixer_cfg_pkg::RESP_OKAY;
  localparam logic [7:0] A_GA = {mixer_cfg_pkg::IDX_GAIN_A, 2'b00};
  localparam logic [7:0] A_MB = {mixer_cfg_pkg::IDX_MIX_GAIN_B, 2'b00};
  localparam logic [7:0] A_GC = {mixer_cfg_pkg::IDX_GAIN_C, 2'b00};
  localparam logic [7:0] A_LD = {mixer_cfg_pkg::IDX_LAG_GAIN_D, 2'b00};
  localparam logic [7:0] A_PH = {mixer_cfg_pkg::IDX_PHASE_AB, 2'b00};
  localparam logic [7:0] A_SY = {mixer_cfg_pkg::IDX_SYNC_CTRL, 2'b00};
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  tb_quad_s in_data = '0;
  tb_quad_s out_data;
  logic in_valid = 1'b0, out_ready = 1'b0, in_ready, out_valid;
  int n_mismatch = 0;
  int tests_run = 0;

  // Free-running sample clock
  always #20 aclk = ~aclk;

  quad_gain_mixer_delay_config u_quad_gain_mixer_delay_config (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .in_data(in_data), .in_valid(in_valid), .in_ready(in_ready),
    .out_data(out_data), .out_valid(out_valid), .out_ready(out_ready)
  );

  // Verdict and end of run
  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string m);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t %s: got %h expected %h", $time, m, got, exp);
    end
  endtask

  task automatic hang(input string m);
    n_mismatch++;
    $display("[ERR] %0t %s: no answer", $time, m);
    test_done();
  endtask

  // Bus write; address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] er);
    logic aw_t, w_t, b_t;
    logic [1:0] resp;
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= {16'h0000, d};
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    b_t = 1'b0;
    for (int i = 0; i < 40 && !b_t; i++) begin
      @(negedge aclk);
      aw_t = s_axi_awvalid && s_axi_awready;
      w_t = s_axi_wvalid && s_axi_wready;
      b_t = s_axi_bvalid === 1'b1;
      resp = s_axi_bresp;
      @(posedge aclk);
      if (aw_t) s_axi_awvalid <= 1'b0;
      if (w_t) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
    // Let one edge pass so a following call never reassigns in this step
    @(posedge aclk);
    if (!b_t) hang("write");
    chk({62'h0, resp}, {62'h0, er}, "write response");
  endtask

  // Bus read with expected data and response
  task automatic rd(input logic [7:0] a, input logic [15:0] ed, input logic [1:0] er);
    logic ar_t, r_t;
    logic [31:0] d;
    logic [1:0] resp;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    r_t = 1'b0;
    for (int i = 0; i < 40 && !r_t; i++) begin
      @(negedge aclk);
      ar_t = s_axi_arvalid && s_axi_arready;
      r_t = s_axi_rvalid === 1'b1;
      d = s_axi_rdata;
      resp = s_axi_rresp;
      @(posedge aclk);
      if (ar_t) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
    @(posedge aclk);
    if (!r_t) hang("read");
    chk({32'h0, d}, {48'h0, ed}, "read data");
    chk({62'h0, resp}, {62'h0, er}, "read response");
  endtask

  task automatic push(input tb_quad_s s);
    logic t;
    in_data <= s;
    in_valid <= 1'b1;
    t = 1'b0;
    for (int i = 0; i < 40 && !t; i++) begin
      @(negedge aclk);
      t = in_ready === 1'b1;
      @(posedge aclk);
    end
    in_valid <= 1'b0;
    @(posedge aclk);
    if (!t) hang("push");
  endtask

  task automatic pop(output tb_quad_s r);
    logic t;
    out_ready <= 1'b1;
    t = 1'b0;
    for (int i = 0; i < 40 && !t; i++) begin
      @(negedge aclk);
      t = out_valid === 1'b1;
      r = out_data;
      @(posedge aclk);
    end
    out_ready <= 1'b0;
    @(posedge aclk);
    if (!t) hang("pop");
  endtask

  function automatic tb_quad_s mk(input logic [15:0] a, b, c, d);
    return tb_quad_s'{d: d, c: c, b: b, a: a};
  endfunction

  // Expected gain product: round at bit 9, shift out ten fraction bits, clip
  function automatic logic [15:0] scale(input logic signed [15:0] x, input logic [10:0] g);
    longint p;
    p = (longint'(x) * longint'(g) + 512) >>> 10;
    if (p > 32767) p = 32767;
    if (p < -32768) p = -32768;
    return p[15:0];
  endfunction

  // Quarter turns of both complex pairs: (i, q) becomes (-q, i)
  function automatic tb_quad_s turn(input tb_quad_s v, input int q);
    tb_quad_s t;
    t = v;
    for (int j = 0; j < q; j++) t = mk(-t.b, t.a, -t.d, t.c);
    return t;
  endfunction

  // Main sequence
  initial begin
    tb_quad_s r, s1, o[4], h[6];
    logic [3:0] modes[6] = '{4'h4, 4'h2, 4'h1, 4'h5, 4'h8, 4'he};
    int steps[6] = '{2, 4, 6, 0, 1, 7};
    int rr, qt;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 4; i++) rd(A_GA + 8'(4 * i), 16'h0400, OK);
    wr(8'h80, 16'h1234, mixer_cfg_pkg::RESP_SLVERR);
    rd(8'h80, 16'h0000, mixer_cfg_pkg::RESP_SLVERR);
    $display("test reset_and_map done");
    // Gains C and D take effect at once, with rounding and clipping
    // Low byte lane only: the upper byte keeps its stored value
    s_axi_wstrb <= 4'h1;
    wr(A_GC, 16'hff23, OK);
    s_axi_wstrb <= 4'hf;
    rd(A_GC, 16'h0423, OK);
    rd(A_PH, 16'h0000, OK);
    wr(A_GC, 16'h0200, OK);
    wr(A_LD, 16'h07ff, OK);
    push(mk(1000, -1000, -1001, 30000));
    pop(r);
    chk(r, mk(1000, -1000, scale(-1001, 11'h200), 16'h7fff), "gain c d high");
    push(mk(0, 0, -1, -30000));
    pop(r);
    chk(r, mk(0, 0, scale(-1, 11'h200), 16'h8000), "gain c d low");
    wr(A_GC, 16'h0400, OK);
    wr(A_LD, 16'h0400, OK);
    $display("test gain_cd done");
    // Gains A and B wait for the phase write
    s1 = mk(2000, 10000, 0, 0);
    wr(A_GA, 16'h0100, OK);
    wr(A_MB, 16'h07ff, OK);
    rd(A_GA, 16'h0100, OK);
    rd({mixer_cfg_pkg::IDX_STATUS, 2'b00}, 16'h0001, OK);
    push(s1);
    pop(r);
    chk(r, s1, "shadow held");
    wr(A_PH, 16'h0000, OK);
    push(s1);
    pop(r);
    chk(r, mk(scale(2000, 11'h100), scale(10000, 11'h7ff), 0, 0), "gain ab");
    wr(A_SY, 16'h0000, OK);
    wr(A_GA, 16'h0400, OK);
    wr(A_MB, 16'h0400, OK);
    wr(A_PH, 16'h0000, OK);
    push(s1);
    pop(r);
    chk(r, mk(scale(2000, 11'h100), scale(10000, 11'h7ff), 0, 0), "no auto sync");
    wr(A_SY, 16'h0001, OK);
    wr(A_PH, 16'h0000, OK);
    push(s1);
    pop(r);
    chk(r, s1, "auto sync apply");
    $display("test gain_ab done");
    // Two-entry buffer fills while the receiver stalls, then drains in order
    push(mk(1, 2, 3, 4));
    push(mk(5, 6, 7, 8));
    @(negedge aclk);
    chk({63'h0, in_ready}, 64'h0, "buffer full");
    @(posedge aclk);
    pop(r);
    chk(r, mk(1, 2, 3, 4), "drain first");
    pop(r);
    chk(r, mk(5, 6, 7, 8), "drain second");
    $display("test buffer done");
    // Output lag: three samples on AB, one on CD
    wr(A_LD, 16'hd400, OK);
    for (int i = 0; i < 6; i++) begin
      h[i] = mk(16'(i * 100 + 1), 16'(i * 100 + 2), 16'(i * 100 + 3), 16'(i * 100 + 4));
      push(h[i]);
      pop(r);
      if (i >= 3) chk(r, mk(h[i-3].a, h[i-3].b, h[i-1].c, h[i-1].d), "lag");
    end
    wr(A_LD, 16'h0400, OK);
    $display("test lag done");
    // Each mixer stage, and a pair that cancels, turns samples by its step
    for (int m = 0; m < 6; m++) begin
      wr(A_MB, {modes[m], 12'h400}, OK);
      wr(A_PH, 16'h0000, OK);
      for (int n = 0; n < 4; n++) begin
        push(mk(1000, 0, 1000, 0));
        pop(o[n]);
      end
      rr = (steps[m] % 2 == 1) ? 2 : 1;
      qt = (steps[m] * rr / 2) % 4;
      chk({63'h0, o[0][31:0] == 32'h0}, 64'h0, "mixer output present");
      for (int n = 0; n + rr < 4; n++) chk(o[n+rr], turn(o[n], qt), "mixer step");
    end
    $display("test mixer done");
    test_done();
  end
endmodule
`default_nettype wire

// File: src/mixer_cfg_pkg.sv
/*
  Constants and types for the quad-channel gain, coarse mixer and output lag block.
  Assumes a 32-bit AXI4-Lite register bus with word-indexed registers.
*/
`default_nettype none
package mixer_cfg_pkg;
  // Register word indices; byte address is four times the index
  localparam logic [5:0] IDX_GAIN_A = 6'h0c;
  localparam logic [5:0] IDX_MIX_GAIN_B = 6'h0d;
  localparam logic [5:0] IDX_GAIN_C = 6'h0e;
  localparam logic [5:0] IDX_LAG_GAIN_D = 6'h0f;
  localparam logic [5:0] IDX_PHASE_AB = 6'h10;
  localparam logic [5:0] IDX_SYNC_CTRL = 6'h1e;
  localparam logic [5:0] IDX_STATUS = 6'h1f;
  localparam int ADDR_W = 8;
  // Field layout
  localparam int GAIN_W = 11;
  localparam int FRAC_BITS = 10;
  localparam int MIX_LSB = 12;
  localparam int LAG_AB_LSB = 14;
  localparam int LAG_CD_LSB = 12;
  localparam int PHASE_W = 12;
  // Values after reset
  localparam logic [15:0] GAIN_REG_RESET = 16'h0400;
  localparam logic [10:0] GAIN_RESET = GAIN_REG_RESET[10:0];
  localparam logic [3:0] MIX_RESET = 4'h0;
  localparam logic [1:0] LAG_RESET = 2'h0;
  localparam logic AUTOSYNC_RESET = 1'b1;
  // Arithmetic constants
  localparam logic signed [27:0] GAIN_ROUND = 28'sh0000200;
  localparam logic signed [35:0] MIX_ROUND = 36'sh000004000;
  localparam logic signed [17:0] COS45 = 18'sh05a82;
  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Four samples moving together, channel a in the low lane
  typedef struct packed {
    logic [15:0] d;
    logic [15:0] c;
    logic [15:0] b;
    logic [15:0] a;
  } sample_quad_s;
  typedef enum logic [0:0] {
    WR_IDLE = 1'b0,
    WR_RESP = 1'b1
  } wr_state_e;
endpackage
`default_nettype wire

// File: src/quad_gain_mixer_delay_config.sv
/*
  Quad-channel gain, coarse mixer and output lag stage with its AXI4-Lite registers.
  Assumes samples arrive from logic on aclk with valid/ready and that the receiver
  may stall; a two-entry buffer holds results while it does.
*/
`timescale 1ns/1ns
`default_nettype none
// Notes on behaviour
// RULE1: Channel A samples are scaled by an unsigned 11-bit gain, 0 to 1.9990.
// RULE2: Channel B samples are scaled by their own unsigned 11-bit gain.
// RULE3: Channel C samples are scaled by their own unsigned 11-bit gain.
// RULE4: Channel D samples are scaled by their own unsigned 11-bit gain.
// RULE5: Gain has one integer bit and ten fraction bits.
// RULE6: Gain registers come out of reset at 0x0400, unity gain, other fields clear.
// RULE7: Mixer select bits 15..12 enable Fs/8, Fs/4, Fs/2 and -Fs/4 stages.
// RULE8: Enabled stages add into one signed shift of n times Fs/8.
// RULE9: Mixer select resets to zero, no shift.
// RULE10: AB pair output lag of 0 to 3 samples from bits 15:14, reset zero.
// RULE11: CD pair output lag of 0 to 3 samples from bits 13:12, reset zero.
// RULE12: Software keeps reserved bits at zero when writing.
// RULE13: AB gains and mixer select apply only on AB phase write with auto-sync.
// RULE14: Gain products are rounded and saturated to 16 bits.
module quad_gain_mixer_delay_config (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire mixer_cfg_pkg::sample_quad_s in_data,
  input wire logic in_valid,
  output logic in_ready,
  output mixer_cfg_pkg::sample_quad_s out_data,
  output logic out_valid,
  input wire logic out_ready
);

  typedef struct packed {
    logic [10:0] gain_a_sh;
    logic [10:0] gain_b_sh;
    logic [3:0] mix_sh;
    logic [10:0] gain_a;
    logic [10:0] gain_b;
    logic [3:0] mix;
    logic [10:0] gain_c;
    logic [10:0] gain_d;
    logic [1:0] lag_ab;
    logic [1:0] lag_cd;
    logic [11:0] phase_ab;
    logic autosync;
    logic pending;
    logic [2:0] phase_acc;
    logic [2:0][31:0] dl_ab;
    logic [2:0][31:0] dl_cd;
    logic [1:0][63:0] fifo;
    logic [1:0] count;
    mixer_cfg_pkg::wr_state_e wst;
    logic aw_got;
    logic w_got;
    logic [5:0] awidx;
    logic [15:0] wdata;
    logic [1:0] wstrb;
    logic [1:0] bresp;
    logic rvalid;
    logic [15:0] rdata;
    logic [1:0] rresp;
  } state_s;

  state_s q;
  state_s next_q;

  // Saturate an 18-bit intermediate back to the 16-bit sample range
  function automatic logic [15:0] sat16(input logic signed [17:0] v);
    if (v[17:15] == 3'h0 || v[17:15] == 3'h7) begin
      return v[15:0];
    end
    return v[17] ? 16'h8000 : 16'h7fff;
  endfunction

  // Multiply by an unsigned gain word with ten fraction bits, round half up
  function automatic logic [15:0] scale(input logic signed [15:0] s, input logic [10:0] g);
    logic signed [27:0] p;
    p = s * $signed({1'b0, g});
    p = p + mixer_cfg_pkg::GAIN_ROUND;
    return sat16(p[27:mixer_cfg_pkg::FRAC_BITS]);
  endfunction

  // Phase step in Fs/8 units from the four stage enables, modulo eight
  function automatic logic [2:0] mix_step(input logic [3:0] m);
    logic [2:0] s;
    s = 3'h0;
    s = s + (m[3] ? 3'h1 : 3'h0);
    s = s + (m[2] ? 3'h2 : 3'h0);
    s = s + (m[1] ? 3'h4 : 3'h0);
    s = s + (m[0] ? 3'h6 : 3'h0);
    return s;
  endfunction

  // Rotate an I/Q pair by k times 45 degrees
  function automatic logic [31:0] mix_rot(input logic signed [15:0] i,
                                          input logic signed [15:0] qv,
                                          input logic [2:0] k);
    logic signed [17:0] ei;
    logic signed [17:0] eq;
    logic signed [17:0] ri;
    logic signed [17:0] rq;
    logic signed [35:0] pi;
    logic signed [35:0] pq;
    ei = {{2{i[15]}}, i};
    eq = {{2{qv[15]}}, qv};
    case (k[2:1])
      2'h0: begin
        ri = ei;
        rq = eq;
      end
      2'h1: begin
        ri = -eq;
        rq = ei;
      end
      2'h2: begin
        ri = -ei;
        rq = -eq;
      end
      default: begin
        ri = eq;
        rq = -ei;
      end
    endcase
    pi = (ri - rq) * mixer_cfg_pkg::COS45 + mixer_cfg_pkg::MIX_ROUND;
    pq = (ri + rq) * mixer_cfg_pkg::COS45 + mixer_cfg_pkg::MIX_ROUND;
    if (k[0]) begin
      ri = pi[32:15];
      rq = pq[32:15];
    end
    return {sat16(ri), sat16(rq)};
  endfunction

  // Readback of one register word; reserved bits read as zero
  function automatic logic [15:0] reg_value(input state_s s, input logic [5:0] idx);
    case (idx)
      mixer_cfg_pkg::IDX_GAIN_A: return {5'h00, s.gain_a_sh};
      mixer_cfg_pkg::IDX_MIX_GAIN_B: return {s.mix_sh, 1'b0, s.gain_b_sh};
      mixer_cfg_pkg::IDX_GAIN_C: return {5'h00, s.gain_c};
      mixer_cfg_pkg::IDX_LAG_GAIN_D: return {s.lag_ab, s.lag_cd, 1'b0, s.gain_d};
      mixer_cfg_pkg::IDX_PHASE_AB: return {4'h0, s.phase_ab};
      mixer_cfg_pkg::IDX_SYNC_CTRL: return {15'h0000, s.autosync};
      mixer_cfg_pkg::IDX_STATUS: return {10'h000, s.phase_acc, s.count, s.pending};
      default: return 16'h0000;
    endcase
  endfunction

  // Whether a word index names a register
  function automatic logic is_mapped(input logic [5:0] idx);
    return (idx >= mixer_cfg_pkg::IDX_GAIN_A && idx <= mixer_cfg_pkg::IDX_PHASE_AB) ||
           idx == mixer_cfg_pkg::IDX_SYNC_CTRL || idx == mixer_cfg_pkg::IDX_STATUS;
  endfunction

  logic [3:0][15:0] in_lanes;
  logic [3:0][10:0] gain_act;
  logic [3:0][15:0] scaled;
  logic [31:0] mixed_ab;
  logic [31:0] mixed_cd;
  logic [3:0][31:0] taps_ab;
  logic [3:0][31:0] taps_cd;
  logic [63:0] push_word;
  logic accept;
  logic pop;
  logic wr_commit;
  logic [15:0] merged;

  // Handshakes and bus outputs
  assign in_ready = (q.count != 2'h2);
  assign out_valid = (q.count != 2'h0);
  assign out_data = q.fifo[0];
  assign accept = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign s_axi_awready = (q.wst == mixer_cfg_pkg::WR_IDLE) && !q.aw_got;
  assign s_axi_wready = (q.wst == mixer_cfg_pkg::WR_IDLE) && !q.w_got;
  assign s_axi_bvalid = (q.wst == mixer_cfg_pkg::WR_RESP);
  assign s_axi_bresp = q.bresp;
  assign s_axi_arready = !q.rvalid;
  assign s_axi_rvalid = q.rvalid;
  assign s_axi_rdata = {16'h0000, q.rdata};
  assign s_axi_rresp = q.rresp;
  assign wr_commit = (q.wst == mixer_cfg_pkg::WR_IDLE) && q.aw_got && q.w_got;

  // Per-channel gain, using the applied gain words
  assign in_lanes = in_data;
  assign gain_act = {q.gain_d, q.gain_c, q.gain_b, q.gain_a};
  for (genvar ch = 0; ch < 4; ch++) begin : g_gain
    assign scaled[ch] = scale(in_lanes[ch], gain_act[ch]); // RULE1 RULE2 RULE3 RULE4 RULE5 RULE14
  end

  // Coarse mixing of each pair, then lag taps per pair
  assign mixed_ab = mix_rot(scaled[0], scaled[1], q.phase_acc); // RULE8
  assign mixed_cd = mix_rot(scaled[2], scaled[3], q.phase_acc);
  assign taps_ab = {q.dl_ab, mixed_ab};
  assign taps_cd = {q.dl_cd, mixed_cd};
  assign push_word = {taps_cd[q.lag_cd][15:0], taps_cd[q.lag_cd][31:16],
                      taps_ab[q.lag_ab][15:0], taps_ab[q.lag_ab][31:16]}; // RULE10 RULE11

  // Byte-lane merge of write data into the current register word
  assign merged = {q.wstrb[1] ? q.wdata[15:8] : reg_value(q, q.awidx)[15:8],
                   q.wstrb[0] ? q.wdata[7:0] : reg_value(q, q.awidx)[7:0]};

  // Next state: bus slave, register writes, datapath and buffer
  always_comb begin
    next_q = q;
    if (s_axi_awvalid && s_axi_awready) begin
      next_q.aw_got = 1'b1;
      next_q.awidx = s_axi_awaddr[7:2];
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_q.w_got = 1'b1;
      next_q.wdata = s_axi_wdata[15:0];
      next_q.wstrb = s_axi_wstrb[1:0];
    end
    case (q.wst)
      mixer_cfg_pkg::WR_IDLE: begin
        if (wr_commit) begin
          next_q.aw_got = 1'b0;
          next_q.w_got = 1'b0;
          next_q.wst = mixer_cfg_pkg::WR_RESP;
          next_q.bresp = is_mapped(q.awidx) ? mixer_cfg_pkg::RESP_OKAY :
                         mixer_cfg_pkg::RESP_SLVERR;
          // Only defined fields are stored, reserved bits are dropped
          case (q.awidx)
            mixer_cfg_pkg::IDX_GAIN_A: begin
              next_q.gain_a_sh = merged[10:0]; // RULE13
              next_q.pending = 1'b1;
            end
            mixer_cfg_pkg::IDX_MIX_GAIN_B: begin
              next_q.mix_sh = merged[mixer_cfg_pkg::MIX_LSB +: 4]; // RULE7 RULE13
              next_q.gain_b_sh = merged[10:0];
              next_q.pending = 1'b1;
            end
            mixer_cfg_pkg::IDX_GAIN_C: begin
              next_q.gain_c = merged[10:0];
            end
            mixer_cfg_pkg::IDX_LAG_GAIN_D: begin
              next_q.lag_ab = merged[mixer_cfg_pkg::LAG_AB_LSB +: 2];
              next_q.lag_cd = merged[mixer_cfg_pkg::LAG_CD_LSB +: 2];
              next_q.gain_d = merged[10:0];
            end
            mixer_cfg_pkg::IDX_PHASE_AB: begin
              next_q.phase_ab = merged[mixer_cfg_pkg::PHASE_W-1:0];
              if (q.autosync) begin
                next_q.gain_a = q.gain_a_sh; // RULE13
                next_q.gain_b = q.gain_b_sh;
                next_q.mix = q.mix_sh;
                next_q.pending = 1'b0;
              end
            end
            mixer_cfg_pkg::IDX_SYNC_CTRL: begin
              next_q.autosync = merged[0];
            end
            default: begin
            end
          endcase
        end
      end
      mixer_cfg_pkg::WR_RESP: begin
        if (s_axi_bready) begin
          next_q.wst = mixer_cfg_pkg::WR_IDLE;
        end
      end
      default: begin
        next_q.wst = mixer_cfg_pkg::WR_IDLE;
      end
    endcase
    // Read channel, one cycle to rvalid
    if (q.rvalid && s_axi_rready) begin
      next_q.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      next_q.rvalid = 1'b1;
      next_q.rdata = reg_value(q, s_axi_araddr[7:2]);
      next_q.rresp = is_mapped(s_axi_araddr[7:2]) ? mixer_cfg_pkg::RESP_OKAY :
                     mixer_cfg_pkg::RESP_SLVERR;
    end
    // Mixer phase and lag lines advance once per accepted sample
    if (accept) begin
      next_q.phase_acc = q.phase_acc + mix_step(q.mix); // RULE7 RULE8
      next_q.dl_ab = {q.dl_ab[1:0], mixed_ab}; // RULE10
      next_q.dl_cd = {q.dl_cd[1:0], mixed_cd}; // RULE11
    end
    // Two-entry buffer, entry 0 is the head
    case ({accept, pop})
      2'b10: begin
        next_q.fifo[q.count[0]] = push_word;
        next_q.count = q.count + 2'h1;
      end
      2'b01: begin
        next_q.fifo[0] = q.fifo[1];
        next_q.count = q.count - 2'h1;
      end
      2'b11: begin
        if (q.count == 2'h1) begin
          next_q.fifo[0] = push_word;
        end else begin
          next_q.fifo[0] = q.fifo[1];
          next_q.fifo[1] = push_word;
        end
      end
      default: begin
      end
    endcase
  end

  // State register with synchronous reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
      q.gain_a_sh <= mixer_cfg_pkg::GAIN_RESET; // RULE6
      q.gain_b_sh <= mixer_cfg_pkg::GAIN_RESET;
      q.gain_a <= mixer_cfg_pkg::GAIN_RESET;
      q.gain_b <= mixer_cfg_pkg::GAIN_RESET;
      q.gain_c <= mixer_cfg_pkg::GAIN_RESET;
      q.gain_d <= mixer_cfg_pkg::GAIN_RESET;
      q.mix_sh <= mixer_cfg_pkg::MIX_RESET; // RULE9
      q.mix <= mixer_cfg_pkg::MIX_RESET;
      q.lag_ab <= mixer_cfg_pkg::LAG_RESET;
      q.lag_cd <= mixer_cfg_pkg::LAG_RESET;
      q.autosync <= mixer_cfg_pkg::AUTOSYNC_RESET;
      q.wst <= mixer_cfg_pkg::WR_IDLE;
    end else begin
      q <= next_q;
    end
  end

  // Checks on the datapath and register behaviour
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  logic signed [16:0] half_a;
  logic apply_ab;
  assign half_a = ($signed({in_lanes[0][15], in_lanes[0]}) + 17'sh00001) >>> 1;
  assign apply_ab = wr_commit && q.awidx == mixer_cfg_pkg::IDX_PHASE_AB && q.autosync;

  unity_gain_a: assert property ( // RULE1
    q.gain_a == 11'h400 |-> scaled[0] == in_lanes[0])
    else $error("channel a unity gain changed the sample");
  unity_gain_b_a: assert property ( // RULE2
    q.gain_b == 11'h400 && accept |-> scaled[1] == in_lanes[1])
    else $error("channel b unity gain changed the sample");
  zero_gain_c_a: assert property ( // RULE3
    q.gain_c == 11'h000 |-> scaled[2] == 16'h0000)
    else $error("channel c zero gain did not give zero");
  unity_gain_d_a: assert property ( // RULE4
    q.gain_d == 11'h400 |-> scaled[3] == in_lanes[3])
    else $error("channel d unity gain changed the sample");
  half_gain_a: assert property ( // RULE5
    q.gain_a == 11'h200 |-> scaled[0] == half_a[15:0])
    else $error("half gain not rounded to one bit right");
  gain_reset_a: assert property ( // RULE6
    $rose(aresetn) |-> q.gain_a == 11'h400 && q.gain_b == 11'h400 &&
      q.gain_c == 11'h400 && q.gain_d == 11'h400)
    else $error("gain words not unity after reset");
  mix_step_a: assert property ( // RULE7
    accept && q.mix == 4'h8 |=> q.phase_acc == $past(q.phase_acc) + 3'h1)
    else $error("fs/8 stage did not step phase by one");
  mix_combine_a: assert property ( // RULE8
    accept && q.mix == 4'he |=> q.phase_acc == $past(q.phase_acc) + 3'h7)
    else $error("combined stages did not give minus one step");
  mix_reset_a: assert property ( // RULE9
    $rose(aresetn) |-> q.mix == 4'h0 && q.mix_sh == 4'h0)
    else $error("mixer select not clear after reset");
  lag_ab_zero_a: assert property ( // RULE10
    accept && !pop && q.count == 2'h0 && q.lag_ab == 2'h0 |=>
      out_valid && out_data.a == $past(mixed_ab[31:16]))
    else $error("ab pair with zero lag not passed straight");
  lag_cd_three_a: assert property ( // RULE11
    accept && !pop && q.count == 2'h0 && q.lag_cd == 2'h3 |=>
      out_data.c == $past(q.dl_cd[2][31:16]))
    else $error("cd pair lag of three wrong");
  apply_ab_a: assert property ( // RULE13
    apply_ab |=> q.gain_a == $past(q.gain_a_sh) && q.mix == $past(q.mix_sh))
    else $error("ab settings not applied on phase write");
  hold_ab_a: assert property ( // RULE13
    !apply_ab |=> $stable(q.gain_a) && $stable(q.gain_b) && $stable(q.mix))
    else $error("ab settings changed without phase write");
  gain_sat_a: assert property ( // RULE14
    q.gain_a == 11'h7ff && in_lanes[0] == 16'h7fff |-> scaled[0] == 16'h7fff)
    else $error("gain product not saturated");

endmodule
`default_nettype wire
